/* File: bench/boolean_stack_rung_evaluator_tb.sv */
// Self-checking bench for the boolean stack rung evaluator
`timescale 1ns/1ps
module boolean_stack_rung_evaluator_tb import bsr_pkg::*;;
  logic clk, nrst, scan_start, scan_done, busy, instr_valid, instr_ready; // Control
  logic [4:0] instr_op, instr_bit_bcd; // Opcode and bit index
  logic [1:0] instr_space, image_space; // Operand spaces
  logic [10:0] instr_addr, image_addr, phys_addr; // Addresses
  logic [15:0] instr_cmp_a, instr_cmp_b, mem_word; // Words
  logic image_bit, phys_in, image_we, image_wdata, phys_we, phys_wdata; // Bits
  logic stack_error, operand_error, rung_result; // Status
  int n_mismatch = 0; // Failed compares
  int n_tests = 0; // All compares
  bsr_rung_evaluator dut (.clk, .nrst, .scan_start, .scan_done, .busy, .instr_valid, .instr_ready, .instr_op,
    .instr_space, .instr_addr, .instr_bit_bcd, .instr_cmp_a, .instr_cmp_b, .image_bit, .mem_word, .phys_in,
    .image_we, .image_space, .image_addr, .image_wdata, .phys_we, .phys_addr, .phys_wdata, .stack_error,
    .operand_error, .rung_result);
  bsr_image_model pm (.clk, .rd_space(instr_space), .rd_addr(instr_addr), .rd_bit(image_bit), .image_we,
    .image_space, .image_addr, .image_wdata, .phys_we, .phys_addr, .phys_wdata);
  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Verdict and end of run
  task automatic close_out();
    $display("compares %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Present one instruction, return at the edge that takes it
  task automatic ins(input bsr_op_e op, input logic [10:0] addr, input logic [4:0] bcd = 5'h0,
    input logic [1:0] sp = BSR_SPACE_IN);
    int n = 0;
    instr_valid <= 1'b1;
    instr_op <= op;
    instr_space <= sp;
    instr_addr <= addr;
    instr_bit_bcd <= bcd;
    do begin
      @(negedge clk);
      n++;
    end while (instr_ready !== 1'b1 && n < 20);
    if (instr_ready !== 1'b1) begin
      n_mismatch++;
      $display("ERROR %0t: instruction not taken", $time);
    end
    @(posedge clk);
  endtask
  // Start a scan from idle
  task automatic start();
    scan_start <= 1'b1;
    @(posedge clk);
    scan_start <= 1'b0;
  endtask
  // Drop valid and let the result land
  task automatic settle();
    instr_valid <= 1'b0;
    @(posedge clk);
    @(negedge clk);
  endtask
  // Check stack top
  task automatic top(input logic exp);
    settle();
    check(rung_result, exp);
    @(posedge clk);
  endtask
  // End the scan, optionally offering a write after the end
  task automatic finish(input bit junk);
    int n = 0;
    ins(BSR_OP_END, 11'h0);
    if (junk) begin
      instr_op <= BSR_OP_OUT;
      instr_space <= BSR_SPACE_OUT;
      instr_addr <= 11'h8;
    end else begin
      instr_valid <= 1'b0;
    end
    do begin
      @(negedge clk);
      n++;
    end while (scan_done !== 1'b1 && n < 10);
    check(scan_done, 1'b1);
    repeat (4) @(posedge clk);
    instr_valid <= 1'b0;
  endtask
  // Every non-immediate contact kind against both stack and operand values
  task automatic t_contacts();
    logic v, s, x;
    for (int k = 1; k <= 12; k++) begin
      for (int b = 0; b < 4; b++) begin
        v = b[0];
        s = b[1];
        x = (k % 2 == 0) ? ~v : v;
        start();
        ins(BSR_OP_RUNG_START, 11'h0);
        ins(BSR_OP_PUSH_CONTACT, s ? 11'h1 : 11'h2);
        ins(bsr_op_e'(k), v ? 11'h1 : 11'h2, v ? 5'h12 : 5'h11);
        if (k <= 4) ins(BSR_OP_SERIES_BRANCH_JOIN, 11'h0);
        top((k > 4 && k < 9) ? (s | x) : (s & x));
        finish(0);
      end
    end
    $display("contacts done");
  endtask
  // Joins, clearing, underflow and overflow
  task automatic t_joins();
    start();
    @(negedge clk);
    check(stack_error, 1'b0);
    @(posedge clk);
    ins(BSR_OP_RUNG_START, 11'h0);
    ins(BSR_OP_PUSH_CONTACT, 11'h2);
    ins(BSR_OP_AND_CONTACT, 11'h1);
    ins(BSR_OP_PUSH_CONTACT, 11'h1);
    ins(BSR_OP_PARALLEL_BRANCH_JOIN, 11'h0);
    top(1'b1);
    check(stack_error, 1'b0);
    ins(BSR_OP_RUNG_START, 11'h0);
    ins(BSR_OP_PUSH_CONTACT, 11'h1);
    ins(BSR_OP_SERIES_BRANCH_JOIN, 11'h0);
    settle();
    check(stack_error, 1'b1);
    @(posedge clk);
    finish(0);
    start();
    ins(BSR_OP_RUNG_START, 11'h0);
    repeat (8) ins(BSR_OP_PUSH_CONTACT, 11'h1);
    top(1'b1);
    check(stack_error, 1'b0);
    ins(BSR_OP_PUSH_CONTACT, 11'h2);
    top(1'b0);
    check(stack_error, 1'b1);
    finish(0);
    $display("joins done");
  endtask
  // All four compare tests below, at and above
  task automatic t_compare();
    logic [15:0] a [3] = '{16'h1234, 16'h1234, 16'h1235};
    logic [15:0] b [3] = '{16'h1235, 16'h1234, 16'h1234};
    logic [3:0] e;
    for (int k = 0; k < 4; k++) begin
      for (int j = 0; j < 3; j++) begin
        e = {a[j] < b[j], a[j] >= b[j], a[j] != b[j], a[j] == b[j]};
        start();
        instr_cmp_a <= a[j];
        instr_cmp_b <= b[j];
        ins(bsr_op_e'(BSR_OP_CMP_EQ + k), 11'h0);
        top(e[k]);
        finish(0);
      end
    end
    $display("compare done");
  endtask
  // Immediate input, immediate output and midline outputs
  task automatic t_immediate();
    phys_in <= 1'b1;
    start();
    repeat (4) @(posedge clk);
    ins(BSR_OP_RUNG_START, 11'h0);
    ins(BSR_OP_PUSH_IMMEDIATE, 11'h3);
    top(1'b1);
    ins(BSR_OP_PUSH_CONTACT, 11'h3);
    top(1'b0);
    ins(BSR_OP_OR_IMMEDIATE, 11'h3);
    ins(BSR_OP_AND_IMMEDIATE, 11'h3);
    top(1'b1);
    ins(BSR_OP_RUNG_START, 11'h0);
    ins(BSR_OP_PUSH_CONTACT, 11'h1);
    ins(BSR_OP_OUT_IMMEDIATE, 11'h5, 5'h0, BSR_SPACE_OUT);
    ins(BSR_OP_OUT, 11'h6, 5'h0, BSR_SPACE_OUT);
    ins(BSR_OP_AND_CONTACT, 11'h1);
    ins(BSR_OP_OUT, 11'h4, 5'h0, BSR_SPACE_OUT);
    ins(BSR_OP_AND_CONTACT, 11'h2);
    ins(BSR_OP_OUT, 11'h7, 5'h0, BSR_SPACE_OUT);
    finish(0);
    check(pm.pin[5], 1'b1);
    check(pm.img[{BSR_SPACE_OUT, 11'h5}], 1'b1);
    check(pm.img[{BSR_SPACE_OUT, 11'h6}], 1'b1);
    check(pm.img[{BSR_SPACE_OUT, 11'h4}], 1'b1);
    check(pm.img[{BSR_SPACE_OUT, 11'h7}], 1'b0);
    check(pm.img[{BSR_SPACE_IN, 11'h3}], 1'b0);
    $display("immediate done");
  endtask
  // Address limit and nothing executed after the end
  task automatic t_end();
    start();
    ins(BSR_OP_PUSH_CONTACT, 11'h1);
    ins(BSR_OP_OUT, 11'h1ff, 5'h0, BSR_SPACE_OUT);
    ins(BSR_OP_OUT, 11'h3ff, 5'h0, BSR_SPACE_CR);
    settle();
    check(operand_error, 1'b0);
    @(posedge clk);
    ins(BSR_OP_OUT, 11'h200, 5'h0, BSR_SPACE_OUT);
    settle();
    check(operand_error, 1'b1);
    @(posedge clk);
    finish(1);
    check(pm.img[{BSR_SPACE_OUT, 11'h1ff}], 1'b1);
    check(pm.img[{BSR_SPACE_CR, 11'h3ff}], 1'b1);
    check(pm.img[{BSR_SPACE_OUT, 11'h8}], 1'b0);
    check(busy, 1'b0);
    start();
    ins(BSR_OP_PUSH_WORD_BIT, 11'h0, 5'h15);
    settle();
    check(operand_error, 1'b0);
    @(posedge clk);
    ins(BSR_OP_PUSH_WORD_BIT, 11'h0, 5'h0a);
    settle();
    check(operand_error, 1'b1);
    @(posedge clk);
    finish(0);
    $display("end done");
  endtask
  // Clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Watchdog
  initial begin
    #3000000;
    n_mismatch++;
    close_out();
  end
  // Main sequence
  initial begin
    nrst = 1'b0;
    scan_start = 1'b0;
    instr_valid = 1'b0;
    instr_op = 5'h00;
    instr_space = 2'h0;
    instr_addr = 11'h000;
    instr_bit_bcd = 5'h00;
    instr_cmp_a = 16'h0000;
    instr_cmp_b = 16'h0000;
    mem_word = 16'h1000;
    phys_in = 1'b0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    pm.img[{BSR_SPACE_IN, 11'h1}] = 1'b1;
    pm.img[{BSR_SPACE_OUT, 11'h7}] = 1'b1;
    @(posedge clk);
    t_contacts();
    t_joins();
    t_compare();
    t_immediate();
    t_end();
    close_out();
  end
endmodule // boolean_stack_rung_evaluator_tb

/* File: bench/bsr_image_model.sv */
// Image register and physical output model facing the rung evaluator
`timescale 1ns/1ps
module bsr_image_model
  import bsr_pkg::*;
(
  // Clock
  input wire logic clk,
  // Point lookup
  input wire logic [1:0] rd_space,
  input wire logic [10:0] rd_addr,
  output logic rd_bit,
  // Image write
  input wire logic image_we,
  input wire logic [1:0] image_space,
  input wire logic [10:0] image_addr,
  input wire logic image_wdata,
  // Physical output write
  input wire logic phys_we,
  input wire logic [10:0] phys_addr,
  input wire logic phys_wdata
);
  logic img [0:8191]; // Image points by space and address
  logic pin [0:2047]; // Physical output pins
  // All points start off
  initial begin
    foreach (img[i]) img[i] = 1'b0;
  end
  // Same-cycle lookup of the addressed point
  assign rd_bit = img[{rd_space, rd_addr}];
  // Image and pin updates
  always @(posedge clk) begin
    if (image_we) img[{image_space, image_addr}] <= image_wdata;
    if (phys_we) pin[phys_addr] <= phys_wdata;
  end
endmodule // bsr_image_model

/* File: inc/bsr_pkg.sv */
// Package of constants and types for the boolean stack rung evaluator
package bsr_pkg;
  // Stack depth and operand widths
  localparam int BSR_STACK_DEPTH = 8;
  localparam int BSR_ADDR_W = 10;
  localparam int BSR_WORD_W = 16;
  localparam int BSR_BIT_IDX_W = 5;
  // Operand limits, octal addresses and BCD bit index
  localparam logic [10:0] BSR_IO_MAX = 11'h1ff;
  localparam logic [10:0] BSR_CR_MAX = 11'h3ff;
  localparam logic [4:0] BSR_BIT_MAX_BCD = 5'h15;
  // Operand spaces
  localparam logic [1:0] BSR_SPACE_IN = 2'h0;
  localparam logic [1:0] BSR_SPACE_OUT = 2'h1;
  localparam logic [1:0] BSR_SPACE_CR = 2'h2;
  // Reset values
  localparam logic [7:0] BSR_STACK_RST = 8'h00;
  localparam logic [3:0] BSR_DEPTH_RST = 4'h0;
  // Opcode field width
  localparam int BSR_OP_W = 5;
  // Instruction codes
  typedef enum logic [4:0] {
    BSR_OP_NOP = 5'h00,
    BSR_OP_PUSH_CONTACT = 5'h01,
    BSR_OP_PUSH_INVERTED_CONTACT = 5'h02,
    BSR_OP_PUSH_WORD_BIT = 5'h03,
    BSR_OP_PUSH_INVERTED_WORD_BIT = 5'h04,
    BSR_OP_OR_CONTACT = 5'h05,
    BSR_OP_OR_INVERTED_CONTACT = 5'h06,
    BSR_OP_OR_WORD_BIT = 5'h07,
    BSR_OP_OR_INVERTED_WORD_BIT = 5'h08,
    BSR_OP_AND_CONTACT = 5'h09,
    BSR_OP_AND_INVERTED_CONTACT = 5'h0a,
    BSR_OP_AND_WORD_BIT = 5'h0b,
    BSR_OP_AND_INVERTED_WORD_BIT = 5'h0c,
    BSR_OP_SERIES_BRANCH_JOIN = 5'h0d,
    BSR_OP_PARALLEL_BRANCH_JOIN = 5'h0e,
    BSR_OP_CMP_EQ = 5'h0f,
    BSR_OP_CMP_NE = 5'h10,
    BSR_OP_CMP_GE = 5'h11,
    BSR_OP_CMP_LT = 5'h12,
    BSR_OP_PUSH_IMMEDIATE = 5'h13,
    BSR_OP_OR_IMMEDIATE = 5'h14,
    BSR_OP_AND_IMMEDIATE = 5'h15,
    BSR_OP_OUT = 5'h16,
    BSR_OP_OUT_IMMEDIATE = 5'h17,
    BSR_OP_RUNG_START = 5'h18,
    BSR_OP_END = 5'h19
  } bsr_op_e;
  // Evaluator states
  typedef enum logic [1:0] {
    BSR_ST_IDLE,
    BSR_ST_RUN,
    BSR_ST_DONE
  } bsr_state_e;
endpackage

/* File: inc/bsr_stack_if.sv */
// Interface between the evaluator core and its boolean stack
`timescale 1ns/1ps
interface bsr_stack_if;
  logic push; // Push new value
  logic pop; // Combine top two
  logic modify; // Replace top value
  logic clear; // Empty the stack
  logic value; // Value to push or write to top
  logic top; // Current top
  logic second; // Level below top
  logic [3:0] depth; // Levels in use
  logic overflow; // Push past capacity
  logic underflow; // Join with fewer than two levels
  modport core (output push, pop, modify, clear, value, input top, second, depth, overflow, underflow);
  modport stack (input push, pop, modify, clear, value, output top, second, depth, overflow, underflow);
endinterface

/* File: verilog/bsr_bool_stack.sv */
// Eight-level boolean stack used to solve one rung
`timescale 1ns/1ps
module bsr_bool_stack
  import bsr_pkg::*;
#(
  parameter int DEPTH = BSR_STACK_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Stack operations
  bsr_stack_if.stack sif
);
  logic [DEPTH-1:0] lvl_reg; // Level 0 is top
  logic [3:0] depth_reg; // Levels in use
  logic [DEPTH-1:0] lvl_next;

  // Next contents, one level at a time
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : g_lvl
      always_comb begin
        lvl_next[gi] = lvl_reg[gi];
        if (sif.clear) begin
          lvl_next[gi] = 1'b0;
        end else if (sif.push) begin
          // New value on top, others move down
          lvl_next[gi] = (gi == 0) ? sif.value : lvl_reg[(gi == 0) ? 0 : gi - 1];
        end else if (sif.pop) begin
          // Top two merge into one, others move up
          if (gi == 0) begin
            lvl_next[gi] = sif.value;
          end else begin
            lvl_next[gi] = (gi == DEPTH - 1) ? 1'b0 : lvl_reg[(gi == DEPTH - 1) ? gi : gi + 1];
          end
        end else if (sif.modify && gi == 0) begin
          lvl_next[gi] = sif.value;
        end
      end
    end
  endgenerate

  // Stack storage
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lvl_reg <= DEPTH'(BSR_STACK_RST);
    end else begin
      lvl_reg <= lvl_next;
    end
  end

  // Depth tracking
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      depth_reg <= BSR_DEPTH_RST;
    end else if (sif.clear) begin
      depth_reg <= BSR_DEPTH_RST;
    end else if (sif.push && depth_reg < 4'(DEPTH)) begin
      depth_reg <= depth_reg + 4'h1;
    end else if (sif.pop && depth_reg > 4'h1) begin
      depth_reg <= depth_reg - 4'h1;
    end
  end

  // Status toward the core
  assign sif.top = lvl_reg[0];
  assign sif.second = lvl_reg[1];
  assign sif.depth = depth_reg;
  assign sif.overflow = sif.push && (depth_reg == 4'(DEPTH));
  assign sif.underflow = sif.pop && (depth_reg < 4'h2);

  // Depth never exceeds capacity
  chk_depth_bound: assert property (@(posedge clk) disable iff (!nrst) depth_reg <= 4'(DEPTH))
    else $error("stack depth above capacity");
  // Push moves old top down one level
  chk_push_shift: assert property (@(posedge clk) disable iff (!nrst)
    (sif.push && !sif.clear) |=> (lvl_reg[1] == $past(lvl_reg[0])))
    else $error("push did not move top down");
endmodule // bsr_bool_stack

/* File: verilog/bsr_rung_evaluator.sv */
// Boolean stack rung evaluator core
`timescale 1ns/1ps
// Notes on behaviour
// - End instruction finishes the scan
// - Loads push value, older levels move down
// - Stack eight deep, overflow flagged
// - Joins merge top two levels
// - Normal load pushes image point value
// - Inverted load pushes complemented image value
// - Word-bit load uses BCD index bit
// - Inverted word-bit load pushes complement
// - Parallel contact ORs image value
// - Parallel inverted contact ORs complement
// - Parallel word-bit ORs bit or complement
// - Series contact ANDs image value
// - Series inverted contact ANDs complement
// - Series word-bit ANDs bit or complement
// - Series join ANDs two branches
// - Parallel join ORs two branches
// - Compare two 4-digit values: eq, ne, ge, lt
// - Immediate input used once, image untouched
// - Immediate output drives pin and image
// - Series contact after output continues rung
module bsr_rung_evaluator
  import bsr_pkg::*;
#(
  parameter int ADDR_W = BSR_ADDR_W,
  parameter int WORD_W = BSR_WORD_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Scan control
  input wire logic scan_start,
  output logic scan_done,
  output logic busy,
  // Instruction stream
  input wire logic instr_valid,
  output logic instr_ready,
  input wire logic [4:0] instr_op,
  input wire logic [1:0] instr_space,
  input wire logic [ADDR_W:0] instr_addr,
  input wire logic [4:0] instr_bit_bcd,
  input wire logic [WORD_W-1:0] instr_cmp_a,
  input wire logic [WORD_W-1:0] instr_cmp_b,
  // Image point read
  input wire logic image_bit,
  // Memory word read (direct or via pointer, resolved outside)
  input wire logic [WORD_W-1:0] mem_word,
  // Physical input pin for immediate reads
  input wire logic phys_in,
  // Image write
  output logic image_we,
  output logic [1:0] image_space,
  output logic [ADDR_W:0] image_addr,
  output logic image_wdata,
  // Physical output for immediate writes
  output logic phys_we,
  output logic [ADDR_W:0] phys_addr,
  output logic phys_wdata,
  // Errors and result
  output logic stack_error,
  output logic operand_error,
  output logic rung_result
);
  bsr_stack_if sif ();

  bsr_state_e state_reg; // Scan state
  logic exec_reg; // Second cycle of a word-bit instruction
  bsr_op_e op_reg; // Last taken opcode, held for trace
  logic [2:0] phys_sync_reg; // Pin synchroniser
  logic phys_in_s; // Agreed pin level
  logic wb_val; // Selected word bit
  logic wb_bad; // Bad bit index
  logic accept; // Instruction taken this cycle
  logic contact; // Contact value for this instruction
  logic cmp_res; // Comparison outcome
  logic range_bad; // Address out of range
  bsr_op_e op; // Decoded opcode

  // Word bit selector, one cycle latency
  bsr_word_bit_select #(.WORD_W(WORD_W)) u_wbs (
    .clk(clk),
    .nrst(nrst),
    .word(mem_word),
    .bit_bcd(instr_bit_bcd),
    .bit_val(wb_val),
    .bad_index(wb_bad)
  );

  // Boolean stack
  bsr_bool_stack #(.DEPTH(BSR_STACK_DEPTH)) u_stack (
    .clk(clk),
    .nrst(nrst),
    .sif(sif)
  );

  // Three-stage synchroniser for the immediate input pin
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phys_sync_reg <= 3'h0;
    end else begin
      phys_sync_reg <= {phys_sync_reg[1:0], phys_in};
    end
  end

  // Pin level held until the last two stages agree
  logic phys_lvl_reg;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phys_lvl_reg <= 1'b0;
    end else if (phys_sync_reg[1] == phys_sync_reg[2]) begin
      phys_lvl_reg <= phys_sync_reg[2];
    end
  end
  assign phys_in_s = phys_lvl_reg;

  // Opcode decode
  always_comb begin
    op = bsr_op_e'(instr_op);
  end

  // Word-bit ops take two cycles while the bit is fetched
  function automatic logic is_word_bit(bsr_op_e o);
    return o inside {BSR_OP_PUSH_WORD_BIT, BSR_OP_PUSH_INVERTED_WORD_BIT, BSR_OP_OR_WORD_BIT,
                     BSR_OP_OR_INVERTED_WORD_BIT, BSR_OP_AND_WORD_BIT, BSR_OP_AND_INVERTED_WORD_BIT};
  endfunction

  // Ready when running and not inside a word-bit fetch
  always_comb begin
    instr_ready = (state_reg == BSR_ST_RUN) && !(is_word_bit(op) && !exec_reg);
    accept = instr_valid && instr_ready;
  end

  // Operand range check per space
  always_comb begin
    case (instr_space)
      BSR_SPACE_IN, BSR_SPACE_OUT: range_bad = 11'(instr_addr) > BSR_IO_MAX;
      BSR_SPACE_CR: range_bad = 11'(instr_addr) > BSR_CR_MAX;
      default: range_bad = 1'b1;
    endcase
  end

  // Comparison of two four-digit BCD values
  always_comb begin
    case (op)
      BSR_OP_CMP_EQ: cmp_res = instr_cmp_a == instr_cmp_b;
      BSR_OP_CMP_NE: cmp_res = instr_cmp_a != instr_cmp_b;
      BSR_OP_CMP_GE: cmp_res = instr_cmp_a >= instr_cmp_b;
      BSR_OP_CMP_LT: cmp_res = instr_cmp_a < instr_cmp_b;
      default: cmp_res = 1'b0;
    endcase
  end

  // Contact value and stack action
  always_comb begin
    contact = 1'b0;
    sif.push = 1'b0;
    sif.pop = 1'b0;
    sif.modify = 1'b0;
    sif.clear = 1'b0;
    sif.value = 1'b0;
    if (state_reg == BSR_ST_IDLE && scan_start) begin
      sif.clear = 1'b1;
    end else if (accept) begin
      case (op)
        BSR_OP_RUNG_START: sif.clear = 1'b1;
        BSR_OP_PUSH_CONTACT: begin
          sif.push = 1'b1;
          sif.value = image_bit;
        end
        BSR_OP_PUSH_INVERTED_CONTACT: begin
          sif.push = 1'b1;
          sif.value = !image_bit;
        end
        BSR_OP_PUSH_WORD_BIT: begin
          sif.push = 1'b1;
          sif.value = wb_val;
        end
        BSR_OP_PUSH_INVERTED_WORD_BIT: begin
          sif.push = 1'b1;
          sif.value = !wb_val;
        end
        BSR_OP_PUSH_IMMEDIATE: begin
          sif.push = 1'b1;
          sif.value = phys_in_s;
        end
        BSR_OP_CMP_EQ, BSR_OP_CMP_NE, BSR_OP_CMP_GE, BSR_OP_CMP_LT: begin
          sif.push = 1'b1;
          sif.value = cmp_res;
        end
        BSR_OP_OR_CONTACT, BSR_OP_OR_INVERTED_CONTACT, BSR_OP_OR_WORD_BIT,
        BSR_OP_OR_INVERTED_WORD_BIT, BSR_OP_OR_IMMEDIATE: begin
          case (op)
            BSR_OP_OR_CONTACT: contact = image_bit;
            BSR_OP_OR_INVERTED_CONTACT: contact = !image_bit;
            BSR_OP_OR_WORD_BIT: contact = wb_val;
            BSR_OP_OR_INVERTED_WORD_BIT: contact = !wb_val;
            default: contact = phys_in_s;
          endcase
          sif.modify = 1'b1;
          sif.value = sif.top | contact;
        end
        BSR_OP_AND_CONTACT, BSR_OP_AND_INVERTED_CONTACT, BSR_OP_AND_WORD_BIT,
        BSR_OP_AND_INVERTED_WORD_BIT, BSR_OP_AND_IMMEDIATE: begin
          case (op)
            BSR_OP_AND_CONTACT: contact = image_bit;
            BSR_OP_AND_INVERTED_CONTACT: contact = !image_bit;
            BSR_OP_AND_WORD_BIT: contact = wb_val;
            BSR_OP_AND_INVERTED_WORD_BIT: contact = !wb_val;
            default: contact = phys_in_s;
          endcase
          // Top stays on stack after outputs, so rung goes on
          sif.modify = 1'b1;
          sif.value = sif.top & contact;
        end
        BSR_OP_SERIES_BRANCH_JOIN: begin
          sif.pop = 1'b1;
          sif.value = sif.top & sif.second;
        end
        BSR_OP_PARALLEL_BRANCH_JOIN: begin
          sif.pop = 1'b1;
          sif.value = sif.top | sif.second;
        end
        default: ;
      endcase
    end
  end

  // Scan state machine
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= BSR_ST_IDLE;
    end else begin
      case (state_reg)
        BSR_ST_IDLE: if (scan_start) begin
          state_reg <= BSR_ST_RUN;
        end
        BSR_ST_RUN: if (accept && op == BSR_OP_END) begin
          state_reg <= BSR_ST_DONE;
        end
        BSR_ST_DONE: state_reg <= BSR_ST_IDLE;
        default: state_reg <= BSR_ST_IDLE;
      endcase
    end
  end

  // Word-bit fetch phase
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      exec_reg <= 1'b0;
    end else if (exec_reg) begin
      exec_reg <= !accept;
    end else begin
      exec_reg <= instr_valid && (state_reg == BSR_ST_RUN) && is_word_bit(op);
    end
  end

  // Held opcode for trace of the last taken instruction
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      op_reg <= BSR_OP_NOP;
    end else if (accept) begin
      op_reg <= op;
    end
  end

  // Scan status outputs
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      scan_done <= 1'b0;
      busy <= 1'b0;
    end else begin
      scan_done <= accept && op == BSR_OP_END;
      busy <= (state_reg == BSR_ST_RUN) && !(accept && op == BSR_OP_END);
    end
  end

  // Coil writes to image and pins, top not popped
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      image_we <= 1'b0;
      image_space <= BSR_SPACE_IN;
      image_addr <= '0;
      image_wdata <= 1'b0;
      phys_we <= 1'b0;
      phys_addr <= '0;
      phys_wdata <= 1'b0;
    end else begin
      image_we <= accept && (op == BSR_OP_OUT || op == BSR_OP_OUT_IMMEDIATE) && !range_bad;
      phys_we <= accept && op == BSR_OP_OUT_IMMEDIATE && !range_bad;
      if (accept) begin
        image_space <= (op == BSR_OP_OUT_IMMEDIATE) ? BSR_SPACE_OUT : instr_space;
        image_addr <= instr_addr;
        image_wdata <= sif.top;
        phys_addr <= instr_addr;
        phys_wdata <= sif.top;
      end
    end
  end

  // Sticky errors, cleared at scan start; a new error wins
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stack_error <= 1'b0;
      operand_error <= 1'b0;
    end else begin
      if (sif.overflow || sif.underflow) begin
        stack_error <= 1'b1;
      end else if (state_reg == BSR_ST_IDLE && scan_start) begin
        stack_error <= 1'b0;
      end
      if (accept && ((range_bad && !is_word_bit(op) && op != BSR_OP_NOP && op != BSR_OP_END &&
          op != BSR_OP_RUNG_START && op != BSR_OP_SERIES_BRANCH_JOIN && op != BSR_OP_PARALLEL_BRANCH_JOIN &&
          !(op inside {BSR_OP_CMP_EQ, BSR_OP_CMP_NE, BSR_OP_CMP_GE, BSR_OP_CMP_LT})) ||
          (is_word_bit(op) && wb_bad))) begin
        operand_error <= 1'b1;
      end else if (state_reg == BSR_ST_IDLE && scan_start) begin
        operand_error <= 1'b0;
      end
    end
  end

  // Registered rung result follows the stack top
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rung_result <= 1'b0;
    end else begin
      rung_result <= sif.top;
    end
  end

  // Named steps of an output instruction
  sequence s_out_taken;
    accept && op == BSR_OP_OUT && !range_bad;
  endsequence

  chk_end_stops: assert property (@(posedge clk) disable iff (!nrst)
    (accept && op == BSR_OP_END) |=> (scan_done && !instr_ready))
    else $error("end did not stop the scan");
  chk_out_copy: assert property (@(posedge clk) disable iff (!nrst)
    s_out_taken |=> (image_we && image_wdata == $past(sif.top) && sif.depth == $past(sif.depth)))
    else $error("output did not copy top");
  chk_imm_out: assert property (@(posedge clk) disable iff (!nrst)
    phys_we |-> (image_we && image_wdata == phys_wdata))
    else $error("immediate output missed image");
  chk_series_join: assert property (@(posedge clk) disable iff (!nrst)
    (accept && op == BSR_OP_SERIES_BRANCH_JOIN && sif.depth > 4'h1) |=>
      (sif.top == ($past(sif.top) & $past(sif.second))))
    else $error("series join wrong");
  chk_par_join: assert property (@(posedge clk) disable iff (!nrst)
    (accept && op == BSR_OP_PARALLEL_BRANCH_JOIN && sif.depth > 4'h1) |=>
      (sif.top == ($past(sif.top) | $past(sif.second))))
    else $error("parallel join wrong");
  chk_and_contact: assert property (@(posedge clk) disable iff (!nrst)
    (accept && op == BSR_OP_AND_CONTACT) |=> (sif.top == ($past(sif.top) & $past(image_bit))))
    else $error("series contact wrong");
  chk_push_inv: assert property (@(posedge clk) disable iff (!nrst)
    (accept && op == BSR_OP_PUSH_INVERTED_CONTACT && sif.depth < 4'h8) |=> (sif.top == !$past(image_bit)))
    else $error("inverted load wrong");
endmodule // bsr_rung_evaluator

/* File: verilog/bsr_word_bit_select.sv */
// Registered word-bit selector with BCD bit index
`timescale 1ns/1ps
module bsr_word_bit_select
  import bsr_pkg::*;
#(
  parameter int WORD_W = BSR_WORD_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Word and index
  input wire logic [WORD_W-1:0] word,
  input wire logic [4:0] bit_bcd,
  // Selected bit and index error
  output logic bit_val,
  output logic bad_index
);
  logic [4:0] bin_idx; // Binary bit number
  logic bcd_ok; // Index legal

  // BCD tens and units into binary, legal 0 to 15
  always_comb begin
    bin_idx = 5'((bit_bcd[4] ? 5'h0a : 5'h00) + {1'b0, bit_bcd[3:0]});
    bcd_ok = (bit_bcd[3:0] <= 4'h9) && (bit_bcd <= BSR_BIT_MAX_BCD);
  end

  // Selected bit out of a register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bit_val <= 1'b0;
      bad_index <= 1'b0;
    end else begin
      bit_val <= bcd_ok ? word[bin_idx[3:0]] : 1'b0;
      bad_index <= !bcd_ok;
    end
  end
endmodule // bsr_word_bit_select
